// >>> hw/hold_timer.sv
// Down-counter that times one reset hold period and pulses when it ends
`timescale 1ns/1ps
module hold_timer #(
    parameter int WIDTH = 28                 // Counter width
) (
    input  wire logic             clk_in,    // System clock
    input  wire logic             rst_b_in,  // Async reset, active low
    input  wire logic             ce_in,     // Clock enable
    input  wire logic             load_in,   // Start a new period
    input  wire logic [WIDTH-1:0] len_in,    // Period length in cycles
    output logic                  done_out   // One-cycle pulse at period end
);

    logic [WIDTH-1:0] cnt_q;                 // Remaining cycles
    logic             busy_q;                // Period in progress
    logic             done_q;                // End pulse
    logic             last;                  // Final cycle of the period

    // Length is captured at load, so later input changes wait for the next period
    assign last     = busy_q && (cnt_q == '0) && !load_in;
    assign done_out = done_q;

    // Count down; a new load restarts the period
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce_in) begin
            done_q <= last;
            if (load_in) begin
                cnt_q  <= len_in - 1'b1;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (cnt_q == '0) begin
                    busy_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end

endmodule : hold_timer

// >>> hw/supervisor_defines.svh
// Constants of the supervisor: timing, register offsets, field positions, reset values
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH

// Clock period of mclk_in (200 MHz)
`define CLK_PERIOD_NS      5
// Converts milliseconds to 64-bit clock cycles
`define MS_TO_CYC(ms)      (64'(ms) * 64'd1000000 / 64'(`CLK_PERIOD_NS))
// Converts nanoseconds to 64-bit clock cycles, rounded down
`define NS_TO_CYC(ns)      (64'(ns) / 64'(`CLK_PERIOD_NS))

// Reset hold minimums per factory option, in ms
`define HOLD_D1_MS         10
`define HOLD_D2_MS         40
`define HOLD_D3_MS         150
`define HOLD_D4_MS         1200
`define HOLD_D5_MS         300
`define HOLD_D6_MS         600

// Watchdog window minimums, in ms (short 1.5 s, long 95 s)
`define WDOG_SHORT_MS      1500
`define WDOG_LONG_MS       95000

// Undervoltage glitch filter length, in ns
`define UV_FILT_NS         40000

// Register byte offsets
`define CTRL_OFS           5'h00
`define STATUS_OFS         5'h04
`define IRQ_STAT_OFS       5'h08
`define IRQ_EN_OFS         5'h0C
`define IRQ_CLR_OFS        5'h10

// Control register fields
`define CTRL_WDOG_EN_BIT   0
`define CTRL_WDOG_LONG_BIT 1
`define CTRL_OPT_LSB       2
`define CTRL_OPT_MSB       4
`define CTRL_USE_SEL_BIT   5
`define CTRL_RST           6'h09

// Status register fields
`define STAT_RESET_BIT     0
`define STAT_UV_BIT        1
`define STAT_MR_BIT        2
`define STAT_SEL_BIT       3

// Interrupt event fields (status, enable and clear share this layout)
`define EV_UV_BIT          0
`define EV_MR_BIT          1
`define EV_WDOG_BIT        2
`define IRQ_EN_RST         3'h0

`endif

// >>> hw/supervisor_pkg.sv
// Types shared by the supervisor design files
package supervisor_pkg;

    // Sequencer states: cause present, hold timing, released
    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_HOLD,
        ST_RUN
    } state_t;

    // Fixed reset hold options, in control register order
    typedef enum logic [2:0] {
        HOLD_10MS,
        HOLD_40MS,
        HOLD_150MS,
        HOLD_1200MS,
        HOLD_300MS,
        HOLD_600MS
    } hold_opt_t;

endpackage : supervisor_pkg

// >>> hw/supervisor_reset_watchdog.sv
// Supervisor reset generator with manual reset, watchdog and register port
//
// Function
// - Supply low asserts reset, both output polarities
// - After supply recovers, hold reset one period
// - Manual low holds reset, plus one period
// - Bouncing manual input only restarts the hold
// - Missing watchdog edge causes one hold period
// - Watchdog clears on reset, manual, edges
// - Watchdog pulses of 150ns are caught
// - Watchdog idle during reset, restarts from zero
// - Select pin picks 10ms or 150ms hold
// - Select change applies only to later periods
// - Filter supply dips shorter than 40us
// - Watchdog window short or long option
// - Fixed hold is one of six options
`timescale 1ns/1ps
`include "supervisor_defines.svh"
module supervisor_reset_watchdog #(
    parameter logic [27:0] HOLD_D1_CYC    = 28'(`MS_TO_CYC(`HOLD_D1_MS)),    // 10 ms
    parameter logic [27:0] HOLD_D2_CYC    = 28'(`MS_TO_CYC(`HOLD_D2_MS)),    // 40 ms
    parameter logic [27:0] HOLD_D3_CYC    = 28'(`MS_TO_CYC(`HOLD_D3_MS)),    // 150 ms
    parameter logic [27:0] HOLD_D4_CYC    = 28'(`MS_TO_CYC(`HOLD_D4_MS)),    // 1200 ms
    parameter logic [27:0] HOLD_D5_CYC    = 28'(`MS_TO_CYC(`HOLD_D5_MS)),    // 300 ms
    parameter logic [27:0] HOLD_D6_CYC    = 28'(`MS_TO_CYC(`HOLD_D6_MS)),    // 600 ms
    parameter logic [35:0] WDOG_SHORT_CYC = 36'(`MS_TO_CYC(`WDOG_SHORT_MS)), // 1.5 s
    parameter logic [35:0] WDOG_LONG_CYC  = 36'(`MS_TO_CYC(`WDOG_LONG_MS)),  // 95 s
    parameter logic [15:0] UV_FILT_CYC    = 16'(`NS_TO_CYC(`UV_FILT_NS))     // 40 us
) (
    input  wire logic        mclk_in,              // System clock, 200 MHz
    input  wire logic        rst_b_in,             // Async reset, active low
    input  wire logic        ce_in,                // Clock enable, freezes all state
    input  wire logic        supply_low_in,        // Supply below threshold
    input  wire logic        manual_reset_n_in,    // Manual reset, active low
    input  wire logic        watchdog_kick_in,     // Watchdog kick from processor
    input  wire logic        hold_time_select_in,  // Hold select: low 10 ms, high 150 ms
    input  wire logic [4:0]  avs_address_in,       // Avalon byte address
    input  wire logic        avs_read_in,          // Avalon read
    input  wire logic        avs_write_in,         // Avalon write
    input  wire logic [31:0] avs_writedata_in,     // Avalon write data
    input  wire logic [3:0]  avs_byteenable_in,    // Avalon byte enables
    output logic [31:0]      avs_readdata_out,     // Avalon read data
    output logic             avs_waitrequest_out,  // Avalon wait request
    output logic             reset_n_out,          // Reset, active-low variant
    output logic             reset_out,            // Reset, active-high variant
    output logic             irq_out               // Level interrupt
);

    // Sequencer state
    supervisor_pkg::state_t state_q;               // Current state
    supervisor_pkg::state_t state_d;               // Next state

    // Input tracking
    logic        kick_q;                           // Kick level last cycle
    logic        mr_low_q;                         // Manual low last cycle
    logic [15:0] filt_cnt_q;                       // Supply-low persistence count
    logic        supply_bad_q;                     // Filtered supply fault
    logic        por_q;                            // Power-on cause
    logic [35:0] wdog_cnt_q;                       // Watchdog cycle count
    logic [27:0] hold_len_q;                       // Length of current hold

    // Registers and outputs
    logic [5:0]  ctrl_q;                           // Control register
    logic [2:0]  irq_stat_q;                       // Sticky events
    logic [2:0]  irq_en_q;                         // Interrupt enables
    logic        irq_q;                            // Interrupt output
    logic        reset_q;                          // Reset asserted
    logic        reset_n_q;                        // Reset, active-low copy
    logic        wait_q;                           // Wait request
    logic [31:0] rdata_q;                          // Read data

    // Decoded wires
    logic        kick_edge;                        // Kick changed level
    logic        mr_low;                           // Manual reset held
    logic        filt_full;                        // Filter length reached
    logic        supply_bad_d;                     // Next filtered fault
    logic        cause;                            // Any reset cause present
    logic        hold_load;                        // Start a hold period
    logic        hold_done;                        // Hold period ended
    logic [27:0] hold_len_d;                       // Length picked at load
    logic [35:0] wdog_limit;                       // Active watchdog window
    logic        wdog_run;                         // Watchdog counting
    logic        wdog_expire;                      // Watchdog window ran out
    logic [2:0]  events;                           // This cycle's events
    logic        access;                           // Bus request present
    logic        take;                             // Request accepted this edge
    logic        wr_ctrl;                          // Write control
    logic        wr_en;                            // Write enables
    logic        wr_clr;                           // Write clear
    logic [31:0] rd_data;                          // Read mux

    // Hold length of a fixed factory option; unused codes fall back to 150 ms
    function automatic logic [27:0] hold_cycles(input logic [2:0] opt);
        case (opt)
            3'(supervisor_pkg::HOLD_10MS):   hold_cycles = HOLD_D1_CYC;
            3'(supervisor_pkg::HOLD_40MS):   hold_cycles = HOLD_D2_CYC;
            3'(supervisor_pkg::HOLD_150MS):  hold_cycles = HOLD_D3_CYC;
            3'(supervisor_pkg::HOLD_1200MS): hold_cycles = HOLD_D4_CYC;
            3'(supervisor_pkg::HOLD_300MS):  hold_cycles = HOLD_D5_CYC;
            3'(supervisor_pkg::HOLD_600MS):  hold_cycles = HOLD_D6_CYC;
            default:                         hold_cycles = HOLD_D3_CYC;
        endcase
    endfunction : hold_cycles

    // Input decode; any sampled level change is an edge, so short pulses count
    assign kick_edge    = watchdog_kick_in ^ kick_q;
    assign mr_low       = !manual_reset_n_in;
    assign filt_full    = (filt_cnt_q == UV_FILT_CYC - 16'h1);
    assign supply_bad_d = supply_low_in && (supply_bad_q || filt_full);
    assign cause        = supply_bad_q || mr_low || por_q;

    // Hold length: select pin when enabled, else fixed option
    assign hold_len_d = ctrl_q[`CTRL_USE_SEL_BIT] ?
                        (hold_time_select_in ? HOLD_D3_CYC : HOLD_D1_CYC) :
                        hold_cycles(ctrl_q[`CTRL_OPT_MSB:`CTRL_OPT_LSB]);

    // Watchdog window and counting condition
    assign wdog_limit  = ctrl_q[`CTRL_WDOG_LONG_BIT] ? WDOG_LONG_CYC : WDOG_SHORT_CYC;
    assign wdog_run    = (state_q == supervisor_pkg::ST_RUN) && ctrl_q[`CTRL_WDOG_EN_BIT]
                         && !mr_low && !kick_edge;
    assign wdog_expire = wdog_run && (wdog_cnt_q == wdog_limit - 36'h1);

    // Hold starts when the last cause clears or the watchdog expires
    assign hold_load = !cause && ((state_q == supervisor_pkg::ST_ACTIVE) ||
                       ((state_q == supervisor_pkg::ST_RUN) && wdog_expire));

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            supervisor_pkg::ST_ACTIVE: begin
                if (!cause) begin
                    state_d = supervisor_pkg::ST_HOLD;
                end
            end
            supervisor_pkg::ST_HOLD: begin
                if (cause) begin
                    state_d = supervisor_pkg::ST_ACTIVE;
                end else if (hold_done) begin
                    state_d = supervisor_pkg::ST_RUN;
                end
            end
            supervisor_pkg::ST_RUN: begin
                if (cause) begin
                    state_d = supervisor_pkg::ST_ACTIVE;
                end else if (wdog_expire) begin
                    state_d = supervisor_pkg::ST_HOLD;
                end
            end
        endcase
    end

    // Hold period timer; length is latched at load
    hold_timer #(
        .WIDTH    (28)
    ) u_hold (
        .clk_in   (mclk_in),
        .rst_b_in (rst_b_in),
        .ce_in    (ce_in),
        .load_in  (hold_load),
        .len_in   (hold_len_d),
        .done_out (hold_done)
    );

    // Events and bus decode
    assign events  = {wdog_expire, mr_low && !mr_low_q, supply_bad_d && !supply_bad_q};
    assign access  = avs_read_in || avs_write_in;
    assign take    = access && !wait_q;
    assign wr_ctrl = take && avs_write_in && avs_byteenable_in[0] && (avs_address_in == `CTRL_OFS);
    assign wr_en   = take && avs_write_in && avs_byteenable_in[0] && (avs_address_in == `IRQ_EN_OFS);
    assign wr_clr  = take && avs_write_in && avs_byteenable_in[0] && (avs_address_in == `IRQ_CLR_OFS);
    assign rd_data = (avs_address_in == `CTRL_OFS)     ? {26'h0, ctrl_q} :
                     (avs_address_in == `STATUS_OFS)   ? {28'h0, hold_time_select_in, mr_low,
                                                          supply_bad_q, reset_q} :
                     (avs_address_in == `IRQ_STAT_OFS) ? {29'h0, irq_stat_q} :
                     (avs_address_in == `IRQ_EN_OFS)   ? {29'h0, irq_en_q} : 32'h0;

    // Input tracking and supply filter
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            kick_q       <= 1'b0;
            mr_low_q     <= 1'b0;
            filt_cnt_q   <= 16'h0;
            supply_bad_q <= 1'b0;
        end else if (ce_in) begin
            kick_q       <= watchdog_kick_in;
            mr_low_q     <= mr_low;
            filt_cnt_q   <= !supply_low_in ? 16'h0 : (filt_full ? filt_cnt_q : filt_cnt_q + 16'h1);
            supply_bad_q <= supply_bad_d;
        end
    end

    // Sequencer, reset outputs and watchdog counter
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q    <= supervisor_pkg::ST_ACTIVE;
            por_q      <= 1'b1;
            reset_q    <= 1'b1;
            reset_n_q  <= 1'b0;
            wdog_cnt_q <= 36'h0;
            hold_len_q <= 28'h0;
        end else if (ce_in) begin
            state_q    <= state_d;
            por_q      <= 1'b0;
            reset_q    <= (state_d != supervisor_pkg::ST_RUN);
            reset_n_q  <= (state_d == supervisor_pkg::ST_RUN);
            wdog_cnt_q <= (wdog_run && !wdog_expire) ? wdog_cnt_q + 36'h1 : 36'h0;
            hold_len_q <= hold_load ? hold_len_d : hold_len_q;
        end
    end

    // Register file, interrupt and Avalon answer; set wins over clear
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_q     <= `CTRL_RST;
            irq_en_q   <= `IRQ_EN_RST;
            irq_stat_q <= 3'h0;
            irq_q      <= 1'b0;
            wait_q     <= 1'b1;
            rdata_q    <= 32'h0;
        end else if (ce_in) begin
            ctrl_q     <= wr_ctrl ? avs_writedata_in[5:0] : ctrl_q;
            irq_en_q   <= wr_en ? avs_writedata_in[2:0] : irq_en_q;
            irq_stat_q <= (irq_stat_q & ~(wr_clr ? avs_writedata_in[2:0] : 3'h0)) | events;
            irq_q      <= |(irq_stat_q & irq_en_q);
            wait_q     <= !(access && wait_q);
            rdata_q    <= (access && wait_q) ? rd_data : rdata_q;
        end
    end

    assign reset_n_out         = reset_n_q;
    assign reset_out           = reset_q;
    assign irq_out             = irq_q;
    assign avs_waitrequest_out = wait_q;
    assign avs_readdata_out    = rdata_q;

    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    supply_rst_a: assert property (ce_in && supply_bad_q |=> reset_q && !reset_n_out)
        else $error("Supply fault did not assert reset");
    hold_len_a: assert property ($fell(reset_q) |-> $past(hold_len_q) >= HOLD_D1_CYC)
        else $error("Reset released before a hold period");
    mr_hold_a: assert property (ce_in && mr_low |=> reset_q ##0
        state_q == supervisor_pkg::ST_ACTIVE)
        else $error("Manual reset not held");
    mr_bounce_a: assert property (ce_in && mr_low && state_q == supervisor_pkg::ST_HOLD
        |=> state_q == supervisor_pkg::ST_ACTIVE ##1 reset_q)
        else $error("Manual bounce did not restart hold");
    wdog_fire_a: assert property (ce_in && wdog_expire && !cause
        |=> state_q == supervisor_pkg::ST_HOLD && reset_q)
        else $error("Watchdog expiry did not reset");
    wdog_clear_a: assert property (ce_in && mr_low |=> wdog_cnt_q == 36'h0)
        else $error("Watchdog not cleared by manual reset");
    kick_catch_a: assert property (ce_in && $changed(watchdog_kick_in)
        |=> wdog_cnt_q == 36'h0)
        else $error("Kick edge missed");
    wdog_idle_a: assert property (ce_in && reset_q |=> wdog_cnt_q == 36'h0)
        else $error("Watchdog counted during reset");
    sel_short_a: assert property (ce_in && hold_load && ctrl_q[`CTRL_USE_SEL_BIT]
        && !hold_time_select_in |=> hold_len_q == HOLD_D1_CYC)
        else $error("Select low did not pick short hold");
    sel_keep_a: assert property (ce_in && state_q == supervisor_pkg::ST_HOLD && !hold_load
        |=> $stable(hold_len_q))
        else $error("Hold length changed mid period");
    uv_filter_a: assert property ($rose(supply_bad_q)
        |-> $past(filt_cnt_q) == UV_FILT_CYC - 16'h1)
        else $error("Supply fault passed the filter early");

    wdog_seen_c: cover property (wdog_expire ##1 reset_q);
    mr_seen_c: cover property (mr_low ##1 !mr_low ##[1:1000] hold_load);
    uv_seen_c: cover property ($rose(supply_bad_q));
    release_c: cover property ($fell(reset_q));

endmodule : supervisor_reset_watchdog

// >>> testbench/cpu_model.sv
// Processor model that services the supervisor watchdog input
`timescale 1ns/1ps
module cpu_model #(
    parameter int PERIOD = 40          // Cycles between kicks
) (
    input  wire logic clk_in,          // System clock
    input  wire logic run_in,          // Program running
    input  wire logic pulse_in,        // Short pulses instead of toggles
    input  wire logic level_in,        // Level the pin sticks at when hung
    output logic      kick_out         // Watchdog kick
);
    int cnt_q = 0;                     // Cycles since last kick
    logic kick_q = 1'b0;               // Kick level driven
    assign kick_out = kick_q;
    // Kick on a fixed period, or leave the pin stuck when hung
    always @(posedge clk_in) begin
        cnt_q <= (cnt_q >= PERIOD - 1) ? 0 : cnt_q + 1;
        if (!run_in) begin
            kick_q <= level_in;                 // Hung program
        end else if (pulse_in) begin
            kick_q <= (cnt_q == 0);             // One-cycle pulse
        end else if (cnt_q == 0) begin
            kick_q <= ~kick_q;                  // Set and cleared at separate points
        end
    end
endmodule : cpu_model

// >>> testbench/supervisor_reset_watchdog_tb.sv
// Self-checking bench of the supervisor reset generator
`timescale 1ns/1ps
module supervisor_reset_watchdog_tb;
    typedef struct {logic [4:0] a; logic [31:0] e;} row_t;
    localparam logic [27:0] HOLD [8] = '{28'h032, 28'h03C, 28'h050, 28'h078,
                                         28'h05A, 28'h064, 28'h050, 28'h050};
    localparam logic [35:0] WIN [3] = '{36'h0C8, 36'h0C8, 36'h190};
    logic        mclk_in;   // Clock
    logic        rst_b_in;  // Reset
    logic        sup_low;   // Supply low
    logic        mr_n;      // Manual reset
    logic        sel;       // Hold select
    logic        kick;      // Watchdog kick
    logic        run;       // Processor running
    logic        pulse;     // Pulse kicks
    logic        lvl;       // Stuck level
    logic        ce;        // Clock enable
    logic [4:0]  addr;      // Bus address
    logic        rd;        // Bus read
    logic        wr;        // Bus write
    logic [31:0] wdata;     // Write data
    logic [3:0]  be;        // Byte enables
    logic [31:0] rdata;     // Read data
    logic        wreq;      // Wait request
    logic        rst_n;     // Reset, low
    logic        rst_o;     // Reset, high
    logic        irq;       // Interrupt
    row_t        rows [7];  // Register defaults
    int          n_fail;    // Mismatches
    int          n_checks;  // Comparisons
    int          n;         // Measured cycles
    int          drop;      // Unexpected levels
    int          cyc = 0;   // Cycle count
    supervisor_reset_watchdog #(.HOLD_D1_CYC(HOLD[0]), .HOLD_D2_CYC(HOLD[1]),
        .HOLD_D3_CYC(HOLD[2]), .HOLD_D4_CYC(HOLD[3]), .HOLD_D5_CYC(HOLD[4]),
        .HOLD_D6_CYC(HOLD[5]), .WDOG_SHORT_CYC(WIN[0]), .WDOG_LONG_CYC(WIN[2]),
        .UV_FILT_CYC(16'h0008)) i_supervisor_reset_watchdog (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce),
        .supply_low_in(sup_low), .manual_reset_n_in(mr_n), .watchdog_kick_in(kick),
        .hold_time_select_in(sel), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .reset_n_out(rst_n),
        .reset_out(rst_o), .irq_out(irq));
    cpu_model i_cpu_model (.clk_in(mclk_in), .run_in(run), .pulse_in(pulse),
        .level_in(lvl), .kick_out(kick));
    // Clock of 5 ns
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    // Cuts a hang short
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            $display("CHECK FAILED run time expected 20000 seen %0d", cyc);
            conclude();
        end
    end
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
        end
    endtask : chk
    // Cycle count must lie within a few cycles above its floor
    task automatic chk_in(input string what, input int lo, input int g);
        n_checks++;
        if (g < lo || g > lo + 6) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, lo, g);
        end
    endtask : chk_in
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] q);
        @(posedge mclk_in);
        addr <= a;
        rd <= ~w;
        wr <= w;
        wdata <= d;
        be <= b;
        do begin
            @(posedge mclk_in);
        end while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, 4'hF, q);
    endtask : wr_reg
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e, input string what);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, 4'hF, q);
        chk(what, e, q);
    endtask : rd_chk
    // Counts edges until reset_out shows the level
    task automatic wait_rst(input logic lv, output int k);
        k = 0;
        do begin
            @(posedge mclk_in);
            k++;
        end while (rst_o !== lv && k < 3000);
    endtask : wait_rst
    task automatic mr_pulse(input int len);
        @(posedge mclk_in);
        mr_n <= 1'b0;
        repeat (len) @(posedge mclk_in);
        mr_n <= 1'b1;
    endtask : mr_pulse
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    // Main sequence
    initial begin
        {rst_b_in, sup_low, sel, pulse, lvl, addr, rd, wr, wdata, be} = '0;
        {mr_n, run, ce} = 3'h7;
        {n_fail, n_checks} = '0;
        rows = '{'{5'h00, 32'h9}, '{5'h04, 32'h0}, '{5'h08, 32'h0}, '{5'h0C, 32'h0},
                 '{5'h10, 32'h0}, '{5'h14, 32'h0}, '{5'h1C, 32'h0}};
        repeat (6) @(posedge mclk_in);
        chk("reset_out in reset", 32'h1, rst_o);
        chk("reset_n_out in reset", 32'h0, rst_n);
        rst_b_in <= 1'b1;
        wait_rst(1'b0, n);
        chk_in("power-on hold", HOLD[2], n);
        foreach (rows[i]) rd_chk(rows[i].a, rows[i].e, "register default");
        $display("test defaults done");
        // Short dip is filtered, long one asserts and then holds
        sup_low <= 1'b1;
        repeat (4) @(posedge mclk_in);
        sup_low <= 1'b0;
        drop = 0;
        repeat (20) @(posedge mclk_in) drop += rst_o;
        chk("short dip reset", 32'h0, drop);
        sup_low <= 1'b1;
        wait_rst(1'b1, n);
        chk_in("supply assert", 8, n);
        chk("reset_n_out low", 32'h0, rst_n);
        sup_low <= 1'b0;
        wait_rst(1'b0, n);
        chk_in("supply hold", HOLD[2], n);
        $display("test supply done");
        // Every hold option, codes 6 and 7 fall back
        for (int k = 0; k < 8; k++) begin
            wr_reg(5'h00, {26'h0, 1'b0, 3'(k), 2'h1});
            mr_pulse(4);
            wait_rst(1'b0, n);
            chk_in("hold option", HOLD[k], n);
        end
        $display("test options done");
        // Bouncing manual input keeps reset up throughout
        wr_reg(5'h00, 32'h09);
        drop = 0;
        for (int j = 0; j < 6; j++) begin
            mr_n <= j[0];
            repeat (j[0] ? 10 : 4) @(posedge mclk_in) drop += (j > 0 && rst_o !== 1'b1);
        end
        chk("bounce release", 32'h0, drop);
        wait_rst(1'b0, n);
        chk_in("bounce hold", HOLD[2], n + 10);
        // Clock enable low freezes the sequencer before the hold starts; the whole hold follows
        mr_pulse(4);
        ce <= 1'b0;
        repeat (100) @(posedge mclk_in);
        ce <= 1'b1;
        wait_rst(1'b0, n);
        chk_in("frozen hold", HOLD[2], n);
        $display("test bounce done");
        // Select pin change mid-hold waits for the next period
        wr_reg(5'h00, 32'h21);
        mr_pulse(4);
        repeat (20) @(posedge mclk_in);
        sel <= 1'b1;
        wait_rst(1'b0, n);
        chk_in("select low hold", HOLD[0], n + 20);
        mr_pulse(4);
        wait_rst(1'b0, n);
        chk_in("select high hold", HOLD[2], n);
        sel <= 1'b0;
        $display("test select done");
        // Stuck kick low, high, then long window
        for (int j = 0; j < 3; j++) begin
            wr_reg(5'h00, (j == 2) ? 32'h0B : 32'h09);
            lvl <= j[0];
            run <= 1'b0;
            mr_pulse(4);
            wait_rst(1'b0, n);
            wait_rst(1'b1, n);
            chk_in("watchdog window", WIN[j], n);
            wait_rst(1'b0, n);
            chk_in("watchdog hold", HOLD[2], n + 2);
        end
        wr_reg(5'h00, 32'h09);
        {run, pulse} <= 2'h3;
        drop = 0;
        repeat (700) @(posedge mclk_in) drop += rst_o;
        chk("short pulses serviced", 32'h0, drop);
        pulse <= 1'b0;
        $display("test watchdog done");
        // Interrupt raise, mask, clear and refused writes
        wr_reg(5'h10, 32'h7);
        rd_chk(5'h08, 32'h0, "status cleared");
        wr_reg(5'h0C, 32'h2);
        mr_pulse(4);
        repeat (4) @(posedge mclk_in);
        chk("irq raised", 32'h1, irq);
        rd_chk(5'h08, 32'h2, "manual event");
        wr_reg(5'h0C, 32'h0);
        repeat (3) @(posedge mclk_in);
        chk("irq masked", 32'h0, irq);
        wr_reg(5'h0C, 32'h2);
        wr_reg(5'h10, 32'h2);
        repeat (3) @(posedge mclk_in);
        chk("irq cleared", 32'h0, irq);
        bus(5'h0C, 1'b1, 32'h5, 4'h0, drop);
        rd_chk(5'h0C, 32'h2, "byte lane off");
        wr_reg(5'h14, 32'hFF);
        rd_chk(5'h14, 32'h0, "unmapped");
        $display("test interrupt done");
        // Reset again in mid-run: reset asserts, registers clear, hold repeats
        rst_b_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        chk("reset_out in mid reset", 32'h1, rst_o);
        rst_b_in <= 1'b1;
        wait_rst(1'b0, n);
        chk_in("mid-run power-on hold", HOLD[2], n);
        rd_chk(5'h0C, 32'h0, "enable after reset");
        $display("test reset done");
        conclude();
    end
endmodule : supervisor_reset_watchdog_tb
